/* core/vrc_pkg.sv */
// constants, codes and types shared by the video ram port controller
`default_nettype none
package vrc_pkg;
  // clock and timing
  localparam int  CLK_PERIOD_NS     = 25;
  localparam real REFRESH_WINDOW_MS = 16.7;
  localparam int  REFRESH_ROWS      = 512;
  localparam int  REFRESH_CYC       =
    int'($floor(REFRESH_WINDOW_MS * 1.0e6 / CLK_PERIOD_NS / REFRESH_ROWS));
  localparam int  PHASE_NS          = 75;
  localparam int  PHASE_CYC         = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  DATA_NS           = 150;
  localparam int  DATA_CYC          = (DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  SER_PERIOD_NS     = 200;
  localparam int  SER_HALF_CYC      = SER_PERIOD_NS / 2 / CLK_PERIOD_NS;

  // widths
  localparam int ADDR_W  = 9;
  localparam int DATA_W  = 32;
  localparam int REG_AW  = 6;
  localparam int CNT_W   = 11;
  localparam int PH_W    = 4;
  localparam int SPLIT_BIT = 8;

  // register byte offsets
  localparam logic [REG_AW-1:0] REG_CMD     = 6'h00;
  localparam logic [REG_AW-1:0] REG_ADDR    = 6'h04;
  localparam logic [REG_AW-1:0] REG_WDATA   = 6'h08;
  localparam logic [REG_AW-1:0] REG_MASK    = 6'h0C;
  localparam logic [REG_AW-1:0] REG_RDATA   = 6'h10;
  localparam logic [REG_AW-1:0] REG_STATUS  = 6'h14;
  localparam logic [REG_AW-1:0] REG_SERCTL  = 6'h18;
  localparam logic [REG_AW-1:0] REG_SERDATA = 6'h1C;
  localparam logic [REG_AW-1:0] REG_SERADDR = 6'h20;

  // field positions
  localparam int ST_BUSY   = 0;
  localparam int ST_REFP   = 1;
  localparam int ST_HALF   = 2;
  localparam int ST_ROW_LO = 16;
  localparam int CTL_RUN   = 0;
  localparam int CTL_EN    = 1;
  localparam int ADR_ROW_LO = 9;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 9'h000;

  // operations written to the command register
  typedef enum logic [3:0] {
    VRC_OP_READ   = 4'h0,
    VRC_OP_WRITE  = 4'h1,
    VRC_OP_MWRITE = 4'h2,
    VRC_OP_BWRITE = 4'h3,
    VRC_OP_XFER   = 4'h4,
    VRC_OP_SPLIT  = 4'h5,
    VRC_OP_RASREF = 4'h6,
    VRC_OP_CBR    = 4'h7
  } vrc_op_t;

  // strobe sequencer states, gray from idle to precharge along the usual path
  typedef enum logic [2:0] {
    VRC_IDLE = 3'b000,
    VRC_ROW  = 3'b001,
    VRC_RAS  = 3'b011,
    VRC_COL  = 3'b010,
    VRC_CAS  = 3'b110,
    VRC_DATA = 3'b111,
    VRC_PRE  = 3'b101,
    VRC_CBR  = 3'b100
  } vrc_state_t;
endpackage : vrc_pkg
`default_nettype wire

/* core/vrc_serial_port.sv */
// serial clock divider and serial word capture for the video ram port
`default_nettype none
module vrc_serial_port
  import vrc_pkg::*;
#(
  parameter int HALF_CYC = SER_HALF_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_run,
  input  wire logic              i_enable,
  input  wire logic              i_hold,
  input  wire logic              i_load,
  input  wire logic [ADDR_W-1:0] i_load_addr,
  input  wire logic [DATA_W-1:0] i_sq,
  input  wire logic              i_half,
  output logic                   o_sclk,
  output logic                   o_se_n,
  output logic [DATA_W-1:0]      o_word,
  output logic                   o_valid,
  output logic [ADDR_W-1:0]      o_addr,
  output logic                   o_half
);
  logic [DATA_W-1:0] sq_meta_q;
  logic [DATA_W-1:0] sq_sync_q;
  logic              half_meta_q;
  logic [PH_W-1:0]   div_q;
  logic              tick;
  logic              rise;
  logic              fall;

  // two-flop synchronisers for the serial pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sq_meta_q   <= ZERO_WORD;
      sq_sync_q   <= ZERO_WORD;
      half_meta_q <= 1'b0;
      o_half      <= 1'b0;
    end else begin
      sq_meta_q   <= i_sq;
      sq_sync_q   <= sq_meta_q;
      half_meta_q <= i_half;
      o_half      <= half_meta_q;
    end
  end

  assign tick = i_run && !i_hold && (div_q == PH_W'(HALF_CYC - 1));
  assign rise = tick && !o_sclk;
  assign fall = tick && o_sclk;

  // divider; the clock parks low while stopped or held for a transfer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q  <= '0;
      o_sclk <= 1'b0;
    end else if (!i_run || i_hold) begin
      div_q  <= '0;
      o_sclk <= 1'b0;
    end else if (tick) begin
      div_q  <= '0;
      o_sclk <= ~o_sclk;
    end else begin
      div_q <= div_q + PH_W'(1);
    end
  end

  // address mirror steps on every rising edge, enabled or not
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr <= ZERO_ADDR;
    end else if (i_load) begin
      o_addr <= i_load_addr;
    end else if (rise) begin
      o_addr <= o_addr + ADDR_W'(1);
    end
  end

  // word captured half a period after the rising edge while enabled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_se_n  <= 1'b1;
      o_word  <= ZERO_WORD;
      o_valid <= 1'b0;
    end else begin
      o_se_n  <= ~i_enable;
      o_valid <= fall && !o_se_n;
      if (fall && !o_se_n) begin
        o_word <= sq_sync_q;
      end
    end
  end
endmodule : vrc_serial_port
`default_nettype wire

/* core/vrc_ctrl.sv */
// host-side controller driving the strobes, addresses and serial clock of a video ram module
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module vrc_ctrl
  import vrc_pkg::*;
#(
  parameter int REF_CYC   = REFRESH_CYC,
  parameter int PH_CYC    = PHASE_CYC,
  parameter int DAT_CYC   = DATA_CYC,
  parameter int SER_HALF  = SER_HALF_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic [DATA_W-1:0] i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic [DATA_W-1:0]      o_reg_rdata,
  output logic                   o_ras_n,
  output logic                   o_cas_n,
  output logic [ADDR_W-1:0]      o_multiplexed_address_lines,
  output logic                   o_transfer_or_output_enable_n,
  output logic                   o_mask_or_write_enable_n,
  output logic                   o_special_function_select,
  output logic [DATA_W-1:0]      o_random_data_lines,
  output logic                   o_random_data_lines_oe,
  input  wire logic [DATA_W-1:0] i_random_data_lines,
  output logic                   o_serial_shift_clock,
  output logic                   o_serial_port_enable_n,
  input  wire logic [DATA_W-1:0] i_serial_data_outputs,
  input  wire logic              i_serial_half_status
);
  vrc_state_t        state_q, state_d;
  vrc_op_t           op_q, cmd_op_q;
  logic              cmd_pend_q;
  logic [PH_W-1:0]   phase_q;
  logic              phase_done;
  logic [17:0]       addr_q;
  logic [DATA_W-1:0] wdata_q, mask_q, rdata_q;
  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;
  logic [CNT_W-1:0]  ref_cnt_q;
  logic              ref_pend_q;
  logic              ref_take;
  logic [ADDR_W-1:0] ref_rows_q;
  logic              ser_run_q, ser_en_q;
  logic [DATA_W-1:0] ser_word;
  logic [ADDR_W-1:0] ser_addr;
  logic              ser_half, ser_hold, ser_load;
  logic [ADDR_W-1:0] row, col;
  logic              ras_d, cas_d, trn_d, mwe_d, spf_d, oe_d;
  logic [ADDR_W-1:0] adr_d;
  logic [DATA_W-1:0] dq_d;

  function automatic logic is_write(input vrc_op_t op);
    return (op == VRC_OP_WRITE) || (op == VRC_OP_MWRITE) || (op == VRC_OP_BWRITE);
  endfunction

  function automatic logic is_xfer(input vrc_op_t op);
    return (op == VRC_OP_XFER) || (op == VRC_OP_SPLIT);
  endfunction

  assign row = addr_q[ADR_ROW_LO +: ADDR_W];
  // top start address bit dropped for split transfers
  assign col = (op_q == VRC_OP_SPLIT) ? {1'b0, addr_q[SPLIT_BIT-1:0]} : addr_q[ADDR_W-1:0];
  assign phase_done = (phase_q == '0);

  // two-flop synchroniser for the random data lines
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_meta_q <= ZERO_WORD;
      dq_sync_q <= ZERO_WORD;
    end else begin
      dq_meta_q <= i_random_data_lines;
      dq_sync_q <= dq_meta_q;
    end
  end

  // refresh timer spreads one cbr per slot over the window
  assign ref_take = (state_q == VRC_IDLE) && ref_pend_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_cnt_q  <= '0;
      ref_pend_q <= 1'b0;
      ref_rows_q <= ZERO_ADDR;
    end else begin
      if (ref_cnt_q == CNT_W'(REF_CYC - 1)) begin
        ref_cnt_q <= '0;
      end else begin
        ref_cnt_q <= ref_cnt_q + CNT_W'(1);
      end
      // a new slot wins over the take in the same cycle
      ref_pend_q <= (ref_cnt_q == CNT_W'(REF_CYC - 1)) || (ref_pend_q && !ref_take);
      if (ref_take) begin
        ref_rows_q <= ref_rows_q + ADDR_W'(1);
      end
    end
  end

  // sequencer; refresh has priority, one strobe cycle at a time
  always_comb begin
    state_d = state_q;
    case (state_q)
      VRC_IDLE: begin
        if (ref_pend_q) begin
          state_d = VRC_CBR;
        end else if (cmd_pend_q) begin
          // a commanded cbr also lowers the column strobe first
          state_d = (cmd_op_q == VRC_OP_CBR) ? VRC_CBR : VRC_ROW;
        end
      end
      VRC_ROW:  if (phase_done) state_d = VRC_RAS;
      VRC_CBR:  if (phase_done) state_d = VRC_RAS;
      VRC_RAS: begin
        if (phase_done) begin
          state_d = ((op_q == VRC_OP_CBR) || (op_q == VRC_OP_RASREF)) ? VRC_PRE : VRC_COL;
        end
      end
      VRC_COL:  if (phase_done) state_d = VRC_CAS;
      VRC_CAS:  if (phase_done) state_d = VRC_DATA;
      VRC_DATA: if (phase_done) state_d = VRC_PRE;
      VRC_PRE:  if (phase_done) state_d = VRC_IDLE;
      default:  state_d = VRC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= VRC_IDLE;
      phase_q <= '0;
      op_q    <= VRC_OP_READ;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        phase_q <= (state_d == VRC_DATA) ? PH_W'(DAT_CYC - 1) : PH_W'(PH_CYC - 1);
      end else if (!phase_done) begin
        phase_q <= phase_q - PH_W'(1);
      end
      if (state_q == VRC_IDLE && ref_pend_q) begin
        op_q <= VRC_OP_CBR;
      end else if (state_q == VRC_IDLE && cmd_pend_q) begin
        op_q <= cmd_op_q;
      end
    end
  end

  // pin levels for the coming state, registered so each pin is a flop
  always_comb begin
    ras_d = 1'b1;
    cas_d = 1'b1;
    trn_d = 1'b1;
    mwe_d = 1'b1;
    spf_d = 1'b0;
    oe_d  = 1'b0;
    adr_d = ZERO_ADDR;
    dq_d  = ZERO_WORD;
    case (state_d)
      VRC_ROW, VRC_RAS: begin
        ras_d = (state_d != VRC_RAS);
        adr_d = row;
        cas_d = !((op_q == VRC_OP_CBR) && (state_d == VRC_RAS));
        trn_d = !is_xfer(op_q);
        mwe_d = !(op_q == VRC_OP_MWRITE);
        spf_d = (op_q == VRC_OP_SPLIT);
        oe_d  = (op_q == VRC_OP_MWRITE);
        dq_d  = (op_q == VRC_OP_MWRITE) ? mask_q : ZERO_WORD;
      end
      VRC_CBR: begin
        cas_d = 1'b0;                                       // column strobe leads
      end
      VRC_COL, VRC_CAS, VRC_DATA: begin
        ras_d = 1'b0;
        cas_d = (state_d == VRC_COL);
        adr_d = col;
        mwe_d = !is_write(op_q);
        spf_d = (op_q == VRC_OP_BWRITE);
        oe_d  = is_write(op_q);
        dq_d  = wdata_q;
        trn_d = !((op_q == VRC_OP_READ) && (state_d == VRC_DATA));
      end
      default: begin
        ras_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ras_n                       <= 1'b1;
      o_cas_n                       <= 1'b1;
      o_multiplexed_address_lines   <= ZERO_ADDR;
      o_transfer_or_output_enable_n <= 1'b1;
      o_mask_or_write_enable_n      <= 1'b1;
      o_special_function_select     <= 1'b0;
      o_random_data_lines           <= ZERO_WORD;
      o_random_data_lines_oe        <= 1'b0;
    end else begin
      o_ras_n                       <= ras_d;
      o_cas_n                       <= cas_d;
      o_multiplexed_address_lines   <= adr_d;
      o_transfer_or_output_enable_n <= trn_d;
      o_mask_or_write_enable_n      <= mwe_d;
      o_special_function_select     <= spf_d;
      o_random_data_lines           <= dq_d;
      o_random_data_lines_oe        <= oe_d;
    end
  end

  // serial clock stops for the whole transfer cycle
  assign ser_hold = is_xfer(op_q) && (state_q != VRC_IDLE);
  assign ser_load = is_xfer(op_q) && (state_q == VRC_PRE) && phase_done;

  vrc_serial_port #(
    .HALF_CYC (SER_HALF)
  ) u_serial (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_run       (ser_run_q),
    .i_enable    (ser_en_q),
    .i_hold      (ser_hold),
    .i_load      (ser_load),
    .i_load_addr (col),
    .i_sq        (i_serial_data_outputs),
    .i_half      (i_serial_half_status),
    .o_sclk      (o_serial_shift_clock),
    .o_se_n      (o_serial_port_enable_n),
    .o_word      (ser_word),
    .o_valid     (),
    .o_addr      (ser_addr),
    .o_half      (ser_half)
  );

  // register writes; a command is refused while one is outstanding
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_pend_q <= 1'b0;
      cmd_op_q   <= VRC_OP_READ;
      addr_q     <= '0;
      wdata_q    <= ZERO_WORD;
      mask_q     <= ZERO_WORD;
      ser_run_q  <= 1'b0;
      ser_en_q   <= 1'b0;
    end else begin
      if (state_q == VRC_IDLE && !ref_pend_q && cmd_pend_q) begin
        cmd_pend_q <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == REG_CMD && !cmd_pend_q && state_q == VRC_IDLE) begin
        cmd_pend_q <= 1'b1;
        cmd_op_q   <= vrc_op_t'(i_reg_wdata[3:0]);
      end
      if (i_reg_wr && i_reg_addr == REG_ADDR) begin
        addr_q <= i_reg_wdata[17:0];
      end else if (i_reg_wr && i_reg_addr == REG_WDATA) begin
        wdata_q <= i_reg_wdata;
      end else if (i_reg_wr && i_reg_addr == REG_MASK) begin
        mask_q <= i_reg_wdata;
      end else if (i_reg_wr && i_reg_addr == REG_SERCTL) begin
        ser_run_q <= i_reg_wdata[CTL_RUN];
        ser_en_q  <= i_reg_wdata[CTL_EN];
      end
    end
  end

  // read word captured at the end of the output-enable phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= ZERO_WORD;
    end else if (state_q == VRC_DATA && phase_done && op_q == VRC_OP_READ) begin
      rdata_q <= dq_sync_q;
    end
  end

  // register reads, data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= ZERO_WORD;
    end else if (!i_reg_rd) begin
      o_reg_rdata <= ZERO_WORD;
    end else if (i_reg_addr == REG_ADDR) begin
      o_reg_rdata <= {14'h0000, addr_q};
    end else if (i_reg_addr == REG_WDATA) begin
      o_reg_rdata <= wdata_q;
    end else if (i_reg_addr == REG_MASK) begin
      o_reg_rdata <= mask_q;
    end else if (i_reg_addr == REG_RDATA) begin
      o_reg_rdata <= rdata_q;
    end else if (i_reg_addr == REG_STATUS) begin
      o_reg_rdata <= {7'h00, ref_rows_q, 13'h0000, ser_half, ref_pend_q,
                      (cmd_pend_q || state_q != VRC_IDLE)};
    end else if (i_reg_addr == REG_SERCTL) begin
      o_reg_rdata <= {30'h0000_0000, ser_en_q, ser_run_q};
    end else if (i_reg_addr == REG_SERDATA) begin
      o_reg_rdata <= ser_word;
    end else if (i_reg_addr == REG_SERADDR) begin
      o_reg_rdata <= {23'h00_0000, ser_addr};
    end else begin
      o_reg_rdata <= ZERO_WORD;
    end
  end

  // checks on the pin sequences
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_cbr_lead;
    !o_cas_n && o_ras_n ##[1:8] $fell(o_ras_n) && !o_cas_n;
  endsequence

  property p_refresh_served;
    $rose(ref_pend_q) |-> ##[1:80] (state_q == VRC_CBR);
  endproperty
  a_refresh_served: assert property (p_refresh_served) else $error("refresh slot not served");

  property p_trn_high_at_ras;
    $fell(o_ras_n) && !is_xfer(op_q) |-> o_transfer_or_output_enable_n;
  endproperty
  a_trn_high_at_ras: assert property (p_trn_high_at_ras) else $error("transfer enable low at ras");

  property p_xfer_we_high;
    $fell(o_ras_n) && is_xfer(op_q) |-> o_mask_or_write_enable_n && !o_transfer_or_output_enable_n;
  endproperty
  a_xfer_we_high: assert property (p_xfer_we_high) else $error("bad transfer strobes");

  property p_mask_at_ras;
    $fell(o_ras_n) && op_q == VRC_OP_MWRITE |->
      o_random_data_lines_oe && o_random_data_lines == mask_q && !o_special_function_select;
  endproperty
  a_mask_at_ras: assert property (p_mask_at_ras) else $error("mask missing at ras");

  property p_block_select;
    $fell(o_cas_n) && !o_ras_n |->
      o_special_function_select == (op_q == VRC_OP_BWRITE);
  endproperty
  a_block_select: assert property (p_block_select) else $error("special select wrong at cas");

  property p_ras_high_idle;
    state_q == VRC_IDLE |-> o_ras_n;
  endproperty
  a_ras_high_idle: assert property (p_ras_high_idle) else $error("ras low while idle");

  property p_row_at_ras;
    $fell(o_ras_n) && o_cas_n |-> o_multiplexed_address_lines == row;
  endproperty
  a_row_at_ras: assert property (p_row_at_ras) else $error("row address wrong at ras");

  property p_split_top_bit;
    $fell(o_cas_n) && op_q == VRC_OP_SPLIT |-> !o_multiplexed_address_lines[SPLIT_BIT];
  endproperty
  a_split_top_bit: assert property (p_split_top_bit) else $error("split start top bit set");

  property p_cbr_order;
    $rose(state_q == VRC_CBR) |-> s_cbr_lead ##[1:8] o_ras_n[*2];
  endproperty
  a_cbr_order: assert property (p_cbr_order) else $error("cbr strobe order broken");

  property p_ser_held;
    ser_hold |-> ##1 !$rose(o_serial_shift_clock);
  endproperty
  a_ser_held: assert property (p_ser_held) else $error("serial clock rose in transfer");
endmodule : vrc_ctrl
`default_nettype wire

/* tb/vrc_vram_model.sv */
// behavioural video ram module seen from the controller's pins
`default_nettype none
module vrc_vram_model
  import vrc_pkg::*;
(
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_trn_n,
  input  wire logic              i_mwe_n,
  input  wire logic              i_spf,
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic              i_sclk,
  input  wire logic              i_ser_en_n,
  output logic [DATA_W-1:0]      o_dq,
  output logic [DATA_W-1:0]      o_sq,
  output logic                   o_half,
  output int                     o_cbr_cnt = 0
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [DATA_W-1:0] COLOR = 32'h0000_0000; // colour register is never loaded
  logic [DATA_W-1:0] mem [logic [17:0]];
  logic [DATA_W-1:0] ser_mem [512];
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] rd_q = 32'h0000_0000;
  logic [ADDR_W-1:0] row_q;
  logic [ADDR_W-1:0] sa_q = 9'h000;
  logic              xfer_q, mw_q, split_q, cbr_q;
  // unwritten words read back as their own address
  function automatic logic [DATA_W-1:0] peek(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : {14'h0000, a};
  endfunction
  // static serial memory, no refresh activity touches it
  initial foreach (ser_mem[i]) ser_mem[i] = 32'h0000_0000;
  // row strobe fall latches row and the mode of the cycle
  always @(negedge i_ras_n) begin
    row_q   <= i_addr;
    xfer_q  <= !i_trn_n && i_cas_n;
    mw_q    <= !i_mwe_n;
    split_q <= i_spf;
    mask_q  <= i_dq;
    cbr_q   <= !i_cas_n;
    if (!i_cas_n) o_cbr_cnt <= o_cbr_cnt + 1;
  end
  // column strobe fall: transfer, write or read
  always @(negedge i_cas_n) if (!i_ras_n && !cbr_q) begin
    if (xfer_q) begin
      for (int i = 0; i < 512; i++) ser_mem[i] = peek({row_q, 9'(i)});
      sa_q = split_q ? {1'b0, i_addr[7:0]} : i_addr;
    end else if (!i_mwe_n && i_spf) begin
      for (int j = 0; j < 4; j++) if (i_dq[j]) mem[{row_q, i_addr[8:2], 2'(j)}] = COLOR;
    end else if (!i_mwe_n) begin
      mem[{row_q, i_addr}] = mw_q ? (peek({row_q, i_addr}) & ~mask_q) | (i_dq & mask_q) : i_dq;
    end else begin
      rd_q = peek({row_q, i_addr});
    end
  end
  // read data only under a late output enable, else the complement of the last read word
  assign o_dq = (!i_ras_n && !i_cas_n && !i_trn_n && !xfer_q && !cbr_q) ? rd_q : ~rd_q;
  // serial side runs on its own clock
  always @(posedge i_sclk) sa_q <= sa_q + 9'h001;
  assign o_sq   = i_ser_en_n ? ~ser_mem[sa_q] : ser_mem[sa_q];
  assign o_half = sa_q[8];
endmodule // vrc_vram_model
`default_nettype wire

/* tb/vrc_ctrl_tb.sv */
// self-checking bench for the video ram port controller
`default_nettype none
module vrc_ctrl_tb
  import vrc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic              i_clk = 1'b0, i_rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [REG_AW-1:0] ra = 6'h00;
  logic [DATA_W-1:0] wd = 32'h0000_0000, rdat, dq_d, dq_w, m_dq, sq, a, v, m, o, sd, e, ep;
  logic              ras_n, cas_n, trn_n, mwe_n, spf, dq_oe, sclk, ser_en_n, half;
  logic [ADDR_W-1:0] ma, st;
  int                err_count = 0, tests_run = 0, seed = 41, cyc = 0, rises = 0, mcbr;
  // clock, hang guard and serial edge count
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done;
    end
  end
  always @(posedge sclk) rises++;
  assign dq_w = dq_oe ? dq_d : m_dq;
  vrc_ctrl #(.REF_CYC(1000)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_multiplexed_address_lines(ma), .o_transfer_or_output_enable_n(trn_n),
    .o_mask_or_write_enable_n(mwe_n), .o_special_function_select(spf),
    .o_random_data_lines(dq_d), .o_random_data_lines_oe(dq_oe), .i_random_data_lines(dq_w),
    .o_serial_shift_clock(sclk), .o_serial_port_enable_n(ser_en_n),
    .i_serial_data_outputs(sq), .i_serial_half_status(half));
  vrc_vram_model u_mem (.i_ras_n(ras_n), .i_cas_n(cas_n), .i_addr(ma), .i_trn_n(trn_n),
    .i_mwe_n(mwe_n), .i_spf(spf), .i_dq(dq_w), .i_sclk(sclk), .i_ser_en_n(ser_en_n),
    .o_dq(m_dq), .o_sq(sq), .o_half(half), .o_cbr_cnt(mcbr));
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // register bus cycles
  task automatic wreg(input logic [REG_AW-1:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    ra <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [REG_AW-1:0] ad, output logic [31:0] d);
    @(posedge i_clk);
    ra <= ad;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // wait until neither busy nor a refresh pending
  task automatic idle;
    logic [31:0] s;
    s = 32'h0000_0003;
    for (int k = 0; k < 200 && s[1:0] != 2'b00; k++) rreg(REG_STATUS, s);
    chk({30'h0000_0000, s[1:0]}, 32'h0000_0000);
  endtask
  task automatic op(input vrc_op_t c, input logic [17:0] ad);
    idle;
    wreg(REG_ADDR, {14'h0000, ad});
    wreg(REG_CMD, {28'h000_0000, c});
    idle;
  endtask
  task automatic rdchk(input logic [17:0] ad, input logic [31:0] x);
    op(VRC_OP_READ, ad);
    rreg(REG_RDATA, o);
    chk(o, x);
  endtask
  task automatic test_done;
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    chk({27'h000_0000, ras_n, cas_n, ser_en_n, sclk, dq_oe}, 32'h0000_001C);
    i_rst_n <= 1'b1;
    // plain and masked writes, corner addresses first
    for (int n = 0; n < 6; n++) begin
      a = (n == 0) ? 32'h0000_0000 : (n == 1) ? 32'hFFFF_FFFF : $random(seed);
      v = $random(seed);
      m = $random(seed);
      wreg(REG_WDATA, v);
      op(VRC_OP_WRITE, a[17:0]);
      rdchk(a[17:0], v);
      wreg(REG_MASK, m);
      wreg(REG_WDATA, ~v);
      op(VRC_OP_MWRITE, a[17:0]);
      rdchk(a[17:0], (v & ~m) | (~v & m));
    end
    // block write touches only the enabled column of the block
    a = $random(seed);
    wreg(REG_WDATA, v);
    op(VRC_OP_WRITE, {a[17:2], 2'b01});
    wreg(REG_WDATA, 32'h0000_0001);
    op(VRC_OP_BWRITE, {a[17:2], 2'b00});
    rdchk({a[17:2], 2'b00}, 32'h0000_0000);
    rdchk({a[17:2], 2'b01}, v);
    // whole and split transfers, serial run with and without output enable
    for (int n = 0; n < 2; n++) begin
      a = $random(seed);
      a[8] = 1'b1;
      st = n ? {1'b0, a[7:0]} : a[8:0];
      op(n ? VRC_OP_SPLIT : VRC_OP_XFER, a[17:0]);
      rreg(REG_SERADDR, o);
      chk(o, {23'h00_0000, st});
      repeat (12) @(posedge i_clk);
      rreg(REG_STATUS, o);
      chk({31'h0000_0000, o[ST_HALF]}, {31'h0000_0000, st[8]});
      rises = 0;
      wreg(REG_SERCTL, n ? 32'h0000_0001 : 32'h0000_0003);
      repeat (50) @(posedge i_clk);
      chk({31'h0000_0000, ser_en_n}, {31'h0000_0000, n[0]});
      repeat (50) @(posedge i_clk);
      wreg(REG_SERCTL, 32'h0000_0000);
      repeat (12) @(posedge i_clk);
      rreg(REG_SERADDR, o);
      chk(o, {23'h00_0000, 9'(st + rises)});
      e = {14'h0000, a[17:9], o[8:0]};
      ep = {14'h0000, a[17:9], o[8:0] - 9'h001};
      if (n == 1) e = sd;
      if (n == 1) ep = sd;
      rreg(REG_SERDATA, sd);
      chk(sd, (sd === ep) ? ep : e);
    end
    // a transfer while the serial clock runs, so the clock pause is exercised
    wreg(REG_SERCTL, 32'h0000_0001);
    op(VRC_OP_XFER, a[17:0]);
    wreg(REG_SERCTL, 32'h0000_0000);
    // both refresh commands, then the automatic refresh count
    op(VRC_OP_RASREF, a[17:0]);
    op(VRC_OP_CBR, a[17:0]);
    idle;
    // counts agree only with no refresh in flight; the commanded cbr is not in the count
    rreg(REG_STATUS, o);
    while (o[1:0] != 2'b00) rreg(REG_STATUS, o);
    chk({23'h00_0000, o[24:16]}, {23'h00_0000, 9'(mcbr - 1)});
    rreg(6'h3C, o);
    chk(o, 32'h0000_0000);
    test_done;
  end
endmodule // vrc_ctrl_tb
`default_nettype wire
